/* File: design/cache_tcm_debug_ecc_regs.sv */
/*
 * Debug access registers for cache and local-memory RAMs plus the ECC
 * error banks, reached by coprocessor transfers. Assumes the RAM side
 * answers each held request with a one-cycle acknowledge, and that error
 * detection reports one event per cycle with its bank and location.
 */
`timescale 1ns/1ns
module cache_tcm_debug_ecc_regs #(
	parameter bit ECC_PRESENT = 1'b1
) (
	// clock and reset
	input wire logic clock,
	input wire logic srst,
	// coprocessor transfer
	input wire logic cp_valid,
	input wire logic cp_write,
	input wire logic cp_privileged,
	input wire logic [3:0] cp_crn,
	input wire logic [2:0] cp_opc2,
	input wire logic [31:0] cp_wdata,
	output logic cp_ready,
	output logic cp_done,
	output logic cp_refused,
	output logic [31:0] cp_rdata,
	// debug RAM access
	output logic ram_req,
	output logic ram_write,
	output logic ram_local_mem,
	output logic ram_instr_side,
	output logic [1:0] ram_way,
	output logic ram_data_array,
	output logic [14:0] ram_address,
	output logic [63:0] ram_wdata,
	output logic [6:0] ram_wecc,
	input wire logic ram_ack,
	input wire logic [63:0] ram_rdata,
	input wire logic [6:0] ram_recc,
	// ECC error reports
	input wire logic err_valid,
	input wire logic [1:0] err_bank,
	input wire logic [3:0] err_way,
	input wire logic err_fatal,
	input wire logic err_in_data_ram,
	input wire logic err_in_tag_ram,
	input wire logic err_in_coherency_ram,
	input wire logic [8:0] err_index,
	input wire logic [2:0] err_word,
	input wire logic [14:0] err_address,
	// bank occupancy
	output logic [3:0] err_bank_full
);

	typedef struct packed
	{
		debug_ecc_pkg::ctl_state_type state;
		logic [31:0] select;
		logic [31:0] data_low;
		logic [31:0] data_high;
		logic [6:0] ecc_chunk;
		logic done;
		logic refused;
		logic [31:0] rdata;
	} ctl_state_type;

	ctl_state_type s_q;
	ctl_state_type s_d;

	// writable bits depend on which layout the written word selects
	function automatic logic [31:0] select_mask(input logic [31:0] value);
		if (value[debug_ecc_pkg::SEL_TCM_BIT])
		begin
			return debug_ecc_pkg::SEL_TCM_MASK;
		end
		return debug_ecc_pkg::SEL_CACHE_MASK;
	endfunction

	// data cache carries only a 32-bit word
	function automatic logic is_data_cache(input logic [31:0] value);
		return !value[debug_ecc_pkg::SEL_TCM_BIT] && !value[debug_ecc_pkg::SEL_SIDE_BIT];
	endfunction

	// one-cycle decode of the transfer address
	function automatic logic is_reg(
		input logic [3:0] crn,
		input logic [2:0] opc2,
		input logic [3:0] want_crn,
		input logic [2:0] want_opc2
	);
		return (crn == want_crn) && (opc2 == want_opc2);
	endfunction

	// error bank wiring
	logic [31:0] cap_word [4];
	logic [31:0] bank_rd [4];
	logic [3:0] bank_write;
	logic [3:0] bank_capture;
	logic take;

	assign take = cp_valid && cp_ready;

	always_comb
	begin
		logic [31:0] cache_word;
		cache_word = 32'h0000_0000;
		cache_word[debug_ecc_pkg::ERR_WAY_LSB +: 4] = err_way;
		cache_word[debug_ecc_pkg::ERR_FATAL_BIT] = err_fatal;
		cache_word[debug_ecc_pkg::ERR_INDEX_LSB +: 9] = err_index;
		cache_word[debug_ecc_pkg::ERR_WORD_LSB +: 3] = err_word;
		cache_word[debug_ecc_pkg::ERR_VALID_BIT] = 1'b1;
		cap_word[0] = cache_word;
		cap_word[0][debug_ecc_pkg::ERR_RAM_LSB +: 3] =
			{err_in_data_ram, err_in_tag_ram, err_in_coherency_ram};
		cap_word[1] = cache_word;
		cap_word[2] = 32'h0000_0000;
		cap_word[2][debug_ecc_pkg::ERR_FATAL_BIT] = err_fatal;
		cap_word[2][debug_ecc_pkg::ERR_ADDR_LSB +: 15] = err_address;
		cap_word[2][debug_ecc_pkg::ERR_VALID_BIT] = 1'b1;
		cap_word[3] = cap_word[2];
	end

	always_comb
	begin
		for (int b = 0; b < 4; b++)
		begin
			bank_capture[b] = err_valid && (err_bank == 2'(b));
			bank_write[b] = take && cp_write && cp_privileged
				&& (cp_crn == debug_ecc_pkg::CRN_DCACHE_ERR + 4'(b))
				&& cp_opc2 < 3'(b < 2 ? debug_ecc_pkg::CACHE_ENTRIES : debug_ecc_pkg::TCM_ENTRIES);
		end
	end

	// the two cache banks keep three entries, local-memory banks one
	error_bank #(
		.DEPTH(debug_ecc_pkg::CACHE_ENTRIES),
		.READ_MASK(debug_ecc_pkg::ERR_DCACHE_MASK)
	) u_dcache_bank (
		.clock(clock),
		.srst(srst),
		.capture_valid(bank_capture[debug_ecc_pkg::BANK_DCACHE]),
		.capture_word(cap_word[0]),
		.sw_write(bank_write[debug_ecc_pkg::BANK_DCACHE]),
		.sw_index(cp_opc2[1:0]),
		.sw_wdata(cp_wdata),
		.rd_word(bank_rd[0]),
		.full(err_bank_full[0])
	);

	error_bank #(
		.DEPTH(debug_ecc_pkg::CACHE_ENTRIES),
		.READ_MASK(debug_ecc_pkg::ERR_ICACHE_MASK)
	) u_icache_bank (
		.clock(clock),
		.srst(srst),
		.capture_valid(bank_capture[debug_ecc_pkg::BANK_ICACHE]),
		.capture_word(cap_word[1]),
		.sw_write(bank_write[debug_ecc_pkg::BANK_ICACHE]),
		.sw_index(cp_opc2[1:0]),
		.sw_wdata(cp_wdata),
		.rd_word(bank_rd[1]),
		.full(err_bank_full[1])
	);

	error_bank #(
		.DEPTH(debug_ecc_pkg::TCM_ENTRIES),
		.READ_MASK(debug_ecc_pkg::ERR_TCM_MASK)
	) u_dtcm_bank (
		.clock(clock),
		.srst(srst),
		.capture_valid(bank_capture[debug_ecc_pkg::BANK_DTCM]),
		.capture_word(cap_word[2]),
		.sw_write(bank_write[debug_ecc_pkg::BANK_DTCM]),
		.sw_index(cp_opc2[1:0]),
		.sw_wdata(cp_wdata),
		.rd_word(bank_rd[2]),
		.full(err_bank_full[2])
	);

	error_bank #(
		.DEPTH(debug_ecc_pkg::TCM_ENTRIES),
		.READ_MASK(debug_ecc_pkg::ERR_TCM_MASK)
	) u_itcm_bank (
		.clock(clock),
		.srst(srst),
		.capture_valid(bank_capture[debug_ecc_pkg::BANK_ITCM]),
		.capture_word(cap_word[3]),
		.sw_write(bank_write[debug_ecc_pkg::BANK_ITCM]),
		.sw_index(cp_opc2[1:0]),
		.sw_wdata(cp_wdata),
		.rd_word(bank_rd[3]),
		.full(err_bank_full[3])
	);

	// transfers stall while a RAM access is in flight
	assign cp_ready = (s_q.state == debug_ecc_pkg::ST_IDLE);
	assign cp_done = s_q.done;
	assign cp_refused = s_q.refused;
	assign cp_rdata = s_q.rdata;

	// RAM request fields come straight from the select, data and chunk registers
	assign ram_req = (s_q.state == debug_ecc_pkg::ST_RAM);
	assign ram_write = s_q.select[debug_ecc_pkg::SEL_DIR_BIT];
	assign ram_local_mem = s_q.select[debug_ecc_pkg::SEL_TCM_BIT];
	assign ram_instr_side = s_q.select[debug_ecc_pkg::SEL_SIDE_BIT];
	assign ram_way = s_q.select[debug_ecc_pkg::SEL_WAY_LSB +: 2];
	assign ram_data_array = s_q.select[debug_ecc_pkg::SEL_TAG_DATA_BIT];
	assign ram_address = s_q.select[debug_ecc_pkg::SEL_ADDR_LSB +: 15];
	assign ram_wdata = {s_q.data_high, s_q.data_low};
	assign ram_wecc = s_q.ecc_chunk;

	always_comb
	begin
		logic known;
		logic [31:0] value;
		known = 1'b0;
		value = 32'h0000_0000;
		s_d = s_q;
		s_d.done = 1'b0;
		s_d.refused = 1'b0;

		// register read decode
		if (is_reg(cp_crn, cp_opc2, debug_ecc_pkg::CRN_DEBUG, debug_ecc_pkg::OPC2_SELECT))
		begin
			known = 1'b1;
			value = s_q.select;
		end
		else if (is_reg(cp_crn, cp_opc2, debug_ecc_pkg::CRN_DEBUG,
			debug_ecc_pkg::OPC2_DATA_LOW))
		begin
			known = 1'b1;
			value = s_q.data_low;
		end
		else if (is_reg(cp_crn, cp_opc2, debug_ecc_pkg::CRN_DEBUG,
			debug_ecc_pkg::OPC2_DATA_HIGH))
		begin
			known = 1'b1;
			value = is_data_cache(s_q.select) ? 32'h0000_0000 : s_q.data_high;
		end
		else if (ECC_PRESENT && is_reg(cp_crn, cp_opc2, debug_ecc_pkg::CRN_DEBUG,
			debug_ecc_pkg::OPC2_ECC))
		begin
			known = 1'b1;
			value = {25'h000_0000, s_q.ecc_chunk};
		end
		else if ((cp_crn == debug_ecc_pkg::CRN_DCACHE_ERR
			|| cp_crn == debug_ecc_pkg::CRN_ICACHE_ERR)
			&& cp_opc2 < 3'(debug_ecc_pkg::CACHE_ENTRIES))
		begin
			known = 1'b1;
			value = bank_rd[cp_crn[1:0] - 2'h2];
		end
		else if ((cp_crn == debug_ecc_pkg::CRN_DTCM_ERR
			|| cp_crn == debug_ecc_pkg::CRN_ITCM_ERR)
			&& cp_opc2 < 3'(debug_ecc_pkg::TCM_ENTRIES))
		begin
			known = 1'b1;
			value = bank_rd[cp_crn[1:0] + 2'h2];
		end

		case (s_q.state)
			debug_ecc_pkg::ST_IDLE:
			begin
				if (take)
				begin
					s_d.done = 1'b1;
					// refusal zeroes the read data and leaves every other register untouched
					if (!known || !cp_privileged)
					begin
						s_d.refused = 1'b1;
						s_d.rdata = 32'h0000_0000;
					end
					else if (!cp_write)
					begin
						s_d.rdata = value;
					end
					else
					begin
						s_d.rdata = 32'h0000_0000;
						if (cp_crn == debug_ecc_pkg::CRN_DEBUG)
						begin
							case (cp_opc2)
								debug_ecc_pkg::OPC2_SELECT:
								begin
									s_d.select = cp_wdata & select_mask(cp_wdata);
									s_d.state = debug_ecc_pkg::ST_RAM;
								end
								debug_ecc_pkg::OPC2_DATA_LOW:
								begin
									s_d.data_low = cp_wdata;
								end
								debug_ecc_pkg::OPC2_DATA_HIGH:
								begin
									if (!is_data_cache(s_q.select))
									begin
										s_d.data_high = cp_wdata;
									end
								end
								debug_ecc_pkg::OPC2_ECC:
								begin
									s_d.ecc_chunk = cp_wdata[6:0];
								end
								default:
								begin
									s_d.refused = 1'b1;
								end
							endcase
						end
					end
				end
			end
			debug_ecc_pkg::ST_RAM:
			begin
				// a read reloads data and chunk before transfers resume
				if (ram_ack)
				begin
					s_d.state = debug_ecc_pkg::ST_IDLE;
					if (!s_q.select[debug_ecc_pkg::SEL_DIR_BIT])
					begin
						s_d.data_low = ram_rdata[31:0];
						s_d.data_high = is_data_cache(s_q.select) ? 32'h0000_0000
							: ram_rdata[63:32];
						s_d.ecc_chunk = ECC_PRESENT ? ram_recc : 7'h00;
					end
				end
			end
			default:
			begin
				s_d.state = debug_ecc_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			s_q.state <= debug_ecc_pkg::ST_IDLE;
			s_q.select <= debug_ecc_pkg::SEL_RESET;
			s_q.data_low <= debug_ecc_pkg::DATA_RESET;
			s_q.data_high <= debug_ecc_pkg::DATA_RESET;
			s_q.ecc_chunk <= 7'h00;
			s_q.done <= 1'b0;
			s_q.refused <= 1'b0;
			s_q.rdata <= 32'h0000_0000;
		end
		else
		begin
			s_q <= s_d;
		end
	end

endmodule

/* File: design/error_bank.sv */
/*
 * One bank of ECC error entries: hardware fills the first free entry,
 * software clears status bits. Assumes the caller builds the captured
 * word in the bank's own layout.
 */
`timescale 1ns/1ns
module error_bank #(
	parameter int DEPTH = 3,
	parameter logic [31:0] READ_MASK = 32'hFFFF_FFFF
) (
	// clock and reset
	input wire logic clock,
	input wire logic srst,
	// hardware capture
	input wire logic capture_valid,
	input wire logic [31:0] capture_word,
	// software access
	input wire logic sw_write,
	input wire logic [1:0] sw_index,
	input wire logic [31:0] sw_wdata,
	output logic [31:0] rd_word,
	output logic full
);

	typedef struct packed
	{
		logic [DEPTH-1:0][31:0] entry;
	} bank_state_type;

	bank_state_type s_q;
	bank_state_type s_d;

	always_comb
	begin
		logic found;
		found = 1'b0;
		s_d = s_q;
		full = 1'b1;
		// software touches only fatal, hard and valid
		if (sw_write && (int'(sw_index) < DEPTH))
		begin
			s_d.entry[sw_index] = (s_q.entry[sw_index] & ~debug_ecc_pkg::ERR_SW_MASK)
				| (sw_wdata & debug_ecc_pkg::ERR_SW_MASK);
		end
		for (int i = 0; i < DEPTH; i++)
		begin
			if (s_d.entry[i][1:0] == debug_ecc_pkg::ERR_STATUS_FREE)
			begin
				full = 1'b0;
				// capture applied after the write so a same-cycle event is kept
				if (capture_valid && !found)
				begin
					s_d.entry[i] = (capture_word & ~debug_ecc_pkg::ERR_HARD_MASK)
						| (s_d.entry[i] & debug_ecc_pkg::ERR_HARD_MASK);
					found = 1'b1;
				end
			end
		end
	end

	// a full bank drops further events; software must drain it
	always_comb
	begin
		if (int'(sw_index) < DEPTH)
		begin
			rd_word = s_q.entry[sw_index] & READ_MASK;
		end
		else
		begin
			rd_word = 32'h0000_0000;
		end
	end

	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			s_q <= '0;
		end
		else
		begin
			s_q <= s_d;
		end
	end

endmodule

/* File: include/debug_ecc_pkg.sv */
/*
 * Shared constants for the cache and local-memory debug access registers
 * and the ECC error banks. Assumes a single core clock and a coprocessor
 * transfer port addressed by primary register and opcode2.
 */
package debug_ecc_pkg;

	// coprocessor register numbers
	localparam logic [3:0] CRN_DEBUG = 4'h1;
	localparam logic [3:0] CRN_DCACHE_ERR = 4'h2;
	localparam logic [3:0] CRN_ICACHE_ERR = 4'h3;
	localparam logic [3:0] CRN_DTCM_ERR = 4'h4;
	localparam logic [3:0] CRN_ITCM_ERR = 4'h5;
	localparam logic [2:0] OPC2_SELECT = 3'h0;
	localparam logic [2:0] OPC2_DATA_LOW = 3'h1;
	localparam logic [2:0] OPC2_DATA_HIGH = 3'h2;
	localparam logic [2:0] OPC2_ECC = 3'h3;

	// operation select fields
	localparam int SEL_TCM_BIT = 22;
	localparam int SEL_TAG_DATA_BIT = 21;
	localparam int SEL_SIDE_BIT = 20;
	localparam int SEL_DIR_BIT = 0;
	localparam int SEL_WAY_LSB = 30;
	localparam int SEL_ADDR_LSB = 2;
	localparam int SEL_INDEX_LSB = 5;
	localparam int SEL_WORD_LSB = 2;
	localparam logic [31:0] SEL_CACHE_MASK = 32'hC070_3FFD;
	localparam logic [31:0] SEL_TCM_MASK = 32'h0051_FFFD;
	localparam logic [31:0] SEL_RESET = 32'h0000_0000;

	// data and check-bit registers
	localparam logic [31:0] ECC_CHUNK_MASK = 32'h0000_007F;
	localparam logic [31:0] DATA_RESET = 32'h0000_0000;

	// error entry fields
	localparam int ERR_WAY_LSB = 28;
	localparam int ERR_FATAL_BIT = 25;
	localparam int ERR_RAM_LSB = 16;
	localparam int ERR_INDEX_LSB = 5;
	localparam int ERR_WORD_LSB = 2;
	localparam int ERR_ADDR_LSB = 2;
	localparam int ERR_HARD_BIT = 1;
	localparam int ERR_VALID_BIT = 0;
	localparam logic [31:0] ERR_DCACHE_MASK = 32'hF207_3FFF;
	localparam logic [31:0] ERR_ICACHE_MASK = 32'hF200_3FFF;
	localparam logic [31:0] ERR_TCM_MASK = 32'h0201_FFFF;
	localparam logic [31:0] ERR_SW_MASK = 32'h0200_0003;
	localparam logic [31:0] ERR_HARD_MASK = 32'h0000_0002;
	localparam logic [31:0] ERR_RESET = 32'h0000_0000;
	localparam logic [1:0] ERR_STATUS_FREE = 2'b00;
	localparam logic [1:0] ERR_STATUS_NEW = 2'b01;
	localparam logic [1:0] ERR_STATUS_PERMANENT = 2'b11;

	// bank sizes
	localparam int CACHE_ENTRIES = 3;
	localparam int TCM_ENTRIES = 1;

	typedef enum logic [1:0]
	{
		BANK_DCACHE = 2'b00,
		BANK_ICACHE = 2'b01,
		BANK_DTCM = 2'b10,
		BANK_ITCM = 2'b11
	} bank_type;

	typedef enum logic [1:0]
	{
		ST_IDLE = 2'b00,
		ST_RAM = 2'b01
	} ctl_state_type;

endpackage

/* File: verif/cache_tcm_debug_ecc_regs_chk.sv */
/* checker for the debug register block: answer timing, refusal, RAM launch.
   assumes one core clock and the top module's port names. */
`timescale 1ns/1ns
module cache_tcm_debug_ecc_regs_chk (
	// clock and reset
	input wire logic clock,
	input wire logic srst,
	// coprocessor transfer
	input wire logic cp_valid,
	input wire logic cp_write,
	input wire logic cp_privileged,
	input wire logic [3:0] cp_crn,
	input wire logic [2:0] cp_opc2,
	input wire logic [31:0] cp_wdata,
	input wire logic cp_ready,
	input wire logic cp_done,
	input wire logic cp_refused,
	input wire logic [31:0] cp_rdata,
	// debug RAM access
	input wire logic ram_req,
	input wire logic ram_write,
	input wire logic ram_local_mem,
	input wire logic ram_instr_side,
	input wire logic [1:0] ram_way,
	input wire logic ram_data_array,
	input wire logic [14:0] ram_address,
	input wire logic ram_ack
);
	default clocking @(posedge clock); endclocking
	default disable iff (srst);
	wire take = cp_valid && cp_ready;
	wire rd_dbg = take && !cp_write && cp_privileged && cp_crn == debug_ecc_pkg::CRN_DEBUG;
	sequence s_sel_take;
		take && cp_write && cp_privileged && cp_crn == debug_ecc_pkg::CRN_DEBUG
			&& cp_opc2 == debug_ecc_pkg::OPC2_SELECT;
	endsequence
	sequence s_ram_busy;
		ram_req && !cp_ready;
	endsequence
	property p_answer; take |=> cp_done; endproperty
	a_answer: assert property (p_answer) else $error("no answer after transfer");
	property p_unpriv; take && !cp_privileged |=> cp_refused && cp_rdata == 32'h0 && !ram_req;
	endproperty
	a_unpriv: assert property (p_unpriv) else $error("unprivileged access served");
	property p_launch; s_sel_take |=> s_ram_busy; endproperty
	a_launch: assert property (p_launch) else $error("select write did not launch");
	property p_fields;
		s_sel_take |=> ram_write == $past(cp_wdata[0]) && ram_instr_side == $past(cp_wdata[20])
			&& ram_local_mem == $past(cp_wdata[22]);
	endproperty
	a_fields: assert property (p_fields) else $error("RAM fields differ");
	property p_cache_fields;
		s_sel_take && !cp_wdata[22] |=> ram_way == $past(cp_wdata[31:30])
			&& ram_data_array == $past(cp_wdata[21]);
	endproperty
	a_cache_fields: assert property (p_cache_fields) else $error("cache fields differ");
	property p_tcm_addr; s_sel_take ##1 ram_local_mem |-> ram_address == $past(cp_wdata[16:2]);
	endproperty
	a_tcm_addr: assert property (p_tcm_addr) else $error("local address differs");
	property p_hold; ram_req && !ram_ack |=> ram_req && $stable(ram_address); endproperty
	a_hold: assert property (p_hold) else $error("RAM request dropped early");
	property p_release; ram_req && ram_ack |=> !ram_req && cp_ready; endproperty
	a_release: assert property (p_release) else $error("RAM request not released");
	property p_high_zero;
		rd_dbg && cp_opc2 == debug_ecc_pkg::OPC2_DATA_HIGH && !ram_local_mem && !ram_instr_side
			|=> cp_rdata == 32'h0;
	endproperty
	a_high_zero: assert property (p_high_zero) else $error("high data not zero");
	property p_chunk; rd_dbg && cp_opc2 == debug_ecc_pkg::OPC2_ECC |=> cp_rdata[31:7] == 25'h0;
	endproperty
	a_chunk: assert property (p_chunk) else $error("chunk upper bits set");
	property p_sel_raz;
		rd_dbg && cp_opc2 == debug_ecc_pkg::OPC2_SELECT |=> (cp_rdata & ~(cp_rdata[22] ?
			debug_ecc_pkg::SEL_TCM_MASK : debug_ecc_pkg::SEL_CACHE_MASK)) == 32'h0;
	endproperty
	a_sel_raz: assert property (p_sel_raz) else $error("select reserved bits set");
endmodule
bind cache_tcm_debug_ecc_regs cache_tcm_debug_ecc_regs_chk u_chk (.clock, .srst, .cp_valid,
	.cp_write, .cp_privileged, .cp_crn, .cp_opc2, .cp_wdata, .cp_ready, .cp_done, .cp_refused,
	.cp_rdata, .ram_req, .ram_write, .ram_local_mem, .ram_instr_side, .ram_way, .ram_data_array,
	.ram_address, .ram_ack);

/* File: verif/cache_tcm_debug_ecc_regs_test.sv */
/* self-checking bench for the debug register block and error banks.
   assumes the design defaults and a bench-driven RAM side. */
`timescale 1ns/1ns
module cache_tcm_debug_ecc_regs_test;
	logic clock, srst, cp_valid, cp_write, cp_privileged, cp_ready, cp_done, cp_refused;
	logic ram_req, ram_write, ram_local_mem, ram_instr_side, ram_data_array, ram_ack, err_valid;
	logic err_fatal, err_in_data_ram, err_in_tag_ram, err_in_coherency_ram;
	logic [3:0] cp_crn, err_way, err_bank_full;
	logic [2:0] cp_opc2, err_word;
	logic [31:0] cp_wdata, cp_rdata, s, w;
	logic [1:0] ram_way, err_bank;
	logic [14:0] ram_address, err_address;
	logic [63:0] ram_wdata, ram_rdata, got_data, exp_w;
	logic [6:0] ram_wecc, ram_recc, got_ecc, exp_e;
	logic [8:0] err_index;
	logic [31:0] ew [4];
	int fails, cmp_count, cycles, i;
	typedef struct {string name; logic [63:0] v;} note_type;
	note_type q[$];
	note_type nt;
	localparam logic [63:0] REF = 64'h1_0000_0000;
	cache_tcm_debug_ecc_regs u_cache_tcm_debug_ecc_regs (.clock, .srst, .cp_valid, .cp_write,
		.cp_privileged, .cp_crn, .cp_opc2, .cp_wdata, .cp_ready, .cp_done, .cp_refused, .cp_rdata,
		.ram_req, .ram_write, .ram_local_mem, .ram_instr_side, .ram_way, .ram_data_array,
		.ram_address, .ram_wdata, .ram_wecc, .ram_ack, .ram_rdata, .ram_recc, .err_valid,
		.err_bank, .err_way, .err_fatal, .err_in_data_ram, .err_in_tag_ram,
		.err_in_coherency_ram, .err_index, .err_word, .err_address, .err_bank_full);
	initial
	begin
		clock = 1'h0;
		forever #4 clock = ~clock;
	end
	task chk(input string n, input logic [63:0] e, input logic [63:0] g);
		cmp_count++;
		if (g !== e)
		begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task end_of_test;
		if (fails == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// request held until the edge that samples ready high
	task xfer(input logic wr, pr, input logic [3:0] c, input logic [2:0] o,
		input logic [31:0] d, input string n, input logic [63:0] e);
		bit ok;
		ok = 0;
		cp_valid <= 1'h1;
		cp_write <= wr;
		cp_privileged <= pr;
		cp_crn <= c;
		cp_opc2 <= o;
		cp_wdata <= d;
		for (int k = 0; k < 50 && !ok; k++)
		begin
			#1 ok = (cp_ready === 1'h1);
			@(posedge clock);
		end
		q.push_back('{n, e});
	endtask
	task settle;
		cp_valid <= 1'h0;
		do @(posedge clock); while (cp_ready !== 1'h1);
	endtask
	task err(input logic [1:0] b, output logic [31:0] x);
		logic [3:0] wy, f;
		logic [8:0] ix;
		logic [2:0] wd;
		logic [14:0] ad;
		wy = 4'h1 << ($urandom % 4);
		ix = 9'($urandom);
		wd = 3'($urandom);
		ad = 15'($urandom);
		f = 4'($urandom);
		err_valid <= 1'h1;
		err_bank <= b;
		err_way <= wy;
		err_index <= ix;
		err_word <= wd;
		err_address <= ad;
		{err_fatal, err_in_data_ram, err_in_tag_ram, err_in_coherency_ram} <= f;
		if (b[1])
			x = {6'h0, f[3], 8'h0, ad, 2'h1};
		else
			x = {wy, 2'h0, f[3], 6'h0, f[2:0] & {3{~b[0]}}, 2'h0, ix, wd, 2'h1};
		@(posedge clock);
		err_valid <= 1'h0;
		@(posedge clock);
	endtask
	// answers are matched oldest first
	always @(posedge clock)
		if (cp_done === 1'h1)
		begin
			if (q.size() > 0)
				nt = q.pop_front();
			else
				nt = '{"stray answer", 64'hFFFF_FFFF_FFFF_FFFF};
			chk(nt.name, nt.v, {31'h0, cp_refused, cp_rdata});
		end
	// RAM side: random answer delay, read data changes every cycle
	always @(posedge clock)
	begin
		if (ram_req === 1'h1 && ram_ack === 1'h1)
		begin
			if (ram_write)
			begin
				chk("ram write data", exp_w, ram_wdata);
				chk("ram write chunk", {57'h0, exp_e}, {57'h0, ram_wecc});
			end
			else
			begin
				got_data = ram_rdata;
				got_ecc = ram_recc;
			end
		end
		ram_ack <= ram_req && !ram_ack && ($urandom % 3 == 0);
		ram_rdata <= {$urandom, $urandom};
		ram_recc <= 7'($urandom);
	end
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			fails++;
			end_of_test();
		end
	end
	initial
	begin
		void'($urandom(84027));
		{cp_valid, cp_write, cp_privileged, cp_crn, cp_opc2, cp_wdata} = '0;
		{err_valid, err_bank, err_way, err_fatal} = '0;
		{err_in_data_ram, err_in_tag_ram, err_in_coherency_ram, err_index, err_word} = '0;
		err_address = '0;
		srst = 1'h1;
		repeat (20) @(posedge clock);
		srst <= 1'h0;
		for (i = 0; i < 4; i++) xfer(0, 1, 4'h1, 3'(i), 0, "debug reset", 0);
		xfer(0, 0, 4'h1, 3'h0, 0, "unprivileged read", REF);
		xfer(1, 0, 4'h1, 3'h0, 32'hFFFF_FFFF, "unprivileged write", REF);
		xfer(0, 1, 4'h2, 3'h3, 0, "unmapped entry", REF);
		xfer(0, 1, 4'h4, 3'h1, 0, "unmapped local entry", REF);
		xfer(0, 1, 4'h1, 3'h0, 0, "select kept", 0);
		s = ($urandom & debug_ecc_pkg::SEL_CACHE_MASK & ~32'h0040_0001) | 32'h0010_0000;
		xfer(1, 1, 4'h1, 3'h0, s, "select icache read", 0);
		settle();
		xfer(0, 1, 4'h1, 3'h1, 0, "low read", {32'h0, got_data[31:0]});
		xfer(0, 1, 4'h1, 3'h2, 0, "high read", {32'h0, got_data[63:32]});
		xfer(0, 1, 4'h1, 3'h3, 0, "chunk read", {57'h0, got_ecc});
		xfer(0, 1, 4'h1, 3'h0, 0, "select read", s);
		exp_w = {$urandom, $urandom};
		w = $urandom;
		exp_e = w[6:0];
		xfer(1, 1, 4'h1, 3'h1, exp_w[31:0], "low write", 0);
		xfer(1, 1, 4'h1, 3'h2, exp_w[63:32], "high write", 0);
		xfer(1, 1, 4'h1, 3'h3, w, "chunk write", 0);
		xfer(0, 1, 4'h1, 3'h3, 0, "chunk masked", {57'h0, exp_e});
		xfer(0, 1, 4'h1, 3'h2, 0, "high kept", {32'h0, exp_w[63:32]});
		xfer(1, 1, 4'h1, 3'h0, s | 32'h1, "select icache write", 0);
		settle();
		s = $urandom & debug_ecc_pkg::SEL_TCM_MASK & ~32'h1 | 32'h0040_0000;
		xfer(1, 1, 4'h1, 3'h0, s, "select local read", 0);
		settle();
		xfer(0, 1, 4'h1, 3'h0, 0, "local select read", s);
		xfer(0, 1, 4'h1, 3'h1, 0, "local low read", {32'h0, got_data[31:0]});
		xfer(1, 1, 4'h1, 3'h0, 0, "select dcache", 0);
		settle();
		xfer(1, 1, 4'h1, 3'h2, $urandom, "dcache high write", 0);
		xfer(0, 1, 4'h1, 3'h2, 0, "dcache high read", 0);
		settle();
		for (i = 0; i < 4; i++) err(2'h0, ew[i]);
		chk("dcache bank full", 1, err_bank_full[0]);
		for (i = 0; i < 3; i++) xfer(0, 1, 4'h2, 3'(i), 0, "dcache entry", ew[i]);
		xfer(1, 1, 4'h2, 3'h4, 0, "wrapped entry write", REF);
		xfer(0, 1, 4'h2, 3'h0, 0, "entry kept", ew[0]);
		xfer(1, 1, 4'h2, 3'h1, 0, "entry clear", 0);
		xfer(0, 1, 4'h2, 3'h1, 0, "entry cleared", ew[1] & ~32'h0200_0003);
		settle();
		err(2'h0, ew[1]);
		xfer(0, 1, 4'h2, 3'h1, 0, "refilled entry", ew[1]);
		settle();
		for (i = 1; i < 4; i++)
		begin
			err(2'(i), w);
			xfer(0, 1, 4'(i + 2), 3'h0, 0, "bank entry", w);
			settle();
		end
		repeat (3) @(posedge clock);
		chk("pending answers", 0, q.size());
		end_of_test();
	end
endmodule
